// ---- include/cocpc_cfg.svh ----
`ifndef COCPC_CFG_SVH
`define COCPC_CFG_SVH

// register byte offsets
`define COCPC_OFF_CTRL 8'h00
`define COCPC_OFF_IDLE 8'h04
`define COCPC_OFF_SECFG 8'h08
`define COCPC_OFF_FMT 8'h0c
`define COCPC_OFF_STATUS 8'h10
`define COCPC_OFF_DIV_FIRST 8'h40
`define COCPC_OFF_DIV_LAST 8'h6c

// control register fields
`define COCPC_CTRL_BUF 0
`define COCPC_CTRL_THREE 1
`define COCPC_CTRL_RSTEN 2
`define COCPC_CTRL_FSEN 3

// reset values
`define COCPC_CTRL_RST 4'hc
`define COCPC_IDLE_RST 4'h0
`define COCPC_SECFG_RST 8'h00
`define COCPC_FMT_RST 8'h55
`define COCPC_DIV_RST 8'h02
`define COCPC_SYNC_RST 10'h01f

// output format codes
`define COCPC_FMT_LVPECL 2'h2
`define COCPC_FMT_CML 2'h3

// bus responses
`define COCPC_RESP_OKAY 2'h0
`define COCPC_RESP_SLVERR 2'h2

// timing
`define COCPC_CLK_NS 20
`define COCPC_SQUELCH_NS 200
`define COCPC_REF_MIN_NS 80
`define COCPC_REF_MAX_NS 2000
`define COCPC_DRIFT_PCT 5

`endif

// ---- include/cocpc_pkg.sv ----
package cocpc_pkg;

    typedef enum logic [1:0] {
        cocpc_st_run,
        cocpc_st_hold,
        cocpc_st_squelch,
        cocpc_st_load
    } cocpc_load_t;

endpackage : cocpc_pkg

// ---- rtl/cocpc_bank_gate.sv ----
`timescale 1ns/1ps
`include "cocpc_cfg.svh"

module cocpc_bank_gate import cocpc_pkg::*; #(
    parameter int DIV_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic [DIV_W-1:0] div,
    input wire logic idle_level,
    input wire logic single_ended,
    input wire logic complementary,
    output logic out_a,
    output logic out_b,
    output logic running
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [DIV_W-1:0] div_q;
        logic phase;
        logic running;
        logic out_a;
        logic out_b;
        logic [DIV_W:0] hold;
    } cocpc_gate_t;

    localparam int STOP_MAX = 2 * (2 ** DIV_W) + 4;

    cocpc_gate_t s;
    cocpc_gate_t n;
    logic wrap;
    logic inphase;

    assign inphase = single_ended & ~complementary;
    assign wrap = (s.cnt + {{(DIV_W-1){1'b0}}, 1'b1}) >= s.div_q || s.div_q == '0;

    always_comb begin
        n = s;
        // divisor only reloads while stopped, so a live clock never changes rate
        if (!s.running) begin
            n.div_q = div;
        end
        n.cnt = wrap ? '0 : s.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
        if (wrap) begin
            n.phase = ~s.phase;
            // stop only on the natural edge into idle, start only on the edge out of it
            if (s.running && !enable && n.phase == idle_level) begin
                n.running = 1'b0;
            end else if (!s.running && enable && n.phase != idle_level) begin
                n.running = 1'b1;
            end
        end
        n.out_a = n.running ? n.phase : idle_level;
        n.out_b = inphase ? n.out_a : ~n.out_a;
        if (n.out_a != s.out_a) begin
            n.hold = '0;
        end else if (!(&s.hold)) begin
            n.hold = s.hold + {{DIV_W{1'b0}}, 1'b1};
        end
        if (!aresetn) begin
            n = '0;
            // differential pair after reset, so the second leg starts inverted
            n.out_b = 1'b1;
            n.div_q = DIV_W'(`COCPC_DIV_RST);
        end
    end

    always_ff @(posedge aclk) begin
        s <= n;
    end

    assign out_a = s.out_a;
    assign out_b = s.out_b;
    assign running = s.running;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stop_bound: assert property ($fell(enable) |-> ##[0:STOP_MAX] (!s.running || enable))
        else $error("bank did not stop after disable");
    a_no_runt: assert property (($changed(s.out_a) && $past(s.running))
            |-> ($past(s.hold) + 1) >= {1'b0, s.div_q})
        else $error("runt half period on bank output");
    a_idle_level: assert property (!s.running |-> s.out_a == $past(idle_level))
        else $error("stopped bank not at idle level");
    a_se_pair: assert property (s.out_b == ($past(inphase) ? s.out_a : ~s.out_a))
        else $error("second output has wrong phase");
    a_div_hold: assert property (s.running && $past(s.running) |-> $stable(s.div_q))
        else $error("divisor changed while running");

endmodule : cocpc_bank_gate

// ---- rtl/cocpc_top.sv ----
// Notes on behaviour
// - each bank has its own disable pin
// - master disable stops every bank
// - bank disable pin low means enabled
// - master disable pin low means enabled
// - stopped bank holds configured idle level
// - banks start and stop without runts
// - two plans: high select picks plan
// - three plans: codes 01,10,11; 00 reserved
// - outputs squelched during plan change
// - no reset pin: plan changes only at power-on
// - unassigned selects load plan 0 on a reset pulse
// - generator: alarm on missing reference or unlock
// - outputs hold frequency while alarm active
// - alarm clears when good reference returns
// - generator: alarm 0 present and locked, else 1
// - buffer mode: alarm high on lost reference
// - single-ended pair in phase or complementary
// - no current-mode format in buffer mode
`timescale 1ns/1ps
`include "cocpc_cfg.svh"

module cocpc_top import cocpc_pkg::*; #(
    parameter int DIV_W = 8,
    parameter int ADDR_W = 8,
    parameter int SQUELCH_CYCLES = (`COCPC_SQUELCH_NS + `COCPC_CLK_NS - 1) / `COCPC_CLK_NS,
    parameter int REF_MIN_CYCLES = (`COCPC_REF_MIN_NS + `COCPC_CLK_NS - 1) / `COCPC_CLK_NS,
    parameter int REF_MAX_CYCLES = `COCPC_REF_MAX_NS / `COCPC_CLK_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bank0_out_disable_n,
    input wire logic bank1_out_disable_n,
    input wire logic bank2_out_disable_n,
    input wire logic bank3_out_disable_n,
    input wire logic master_out_disable_n,
    input wire logic plan_select_low,
    input wire logic plan_select_high,
    input wire logic device_reset,
    input wire logic pll_locked,
    input wire logic ref_clk,
    output logic [3:0] bank_out_a,
    output logic [3:0] bank_out_b,
    output logic [7:0] bank_format,
    output logic [1:0] active_plan,
    output logic ref_missing_alarm
);

    typedef struct packed {
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic ref_q;
        logic [15:0] ref_cnt;
        logic ref_present;
        logic alarm;
        cocpc_load_t st;
        logic [7:0] sq_cnt;
        logic [1:0] plan;
        logic [3:0] ctrl;
        logic [3:0] idle;
        logic [7:0] secfg;
        logic [7:0] fmt;
        logic [7:0] fmt_out;
        logic [11:0][DIV_W-1:0] div;
        logic aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cocpc_state_t;

    localparam int STOP_MAX = 2 * (2 ** DIV_W) + 4;

    cocpc_state_t s;
    cocpc_state_t n;
    logic [9:0] pin_in;
    logic [3:0] bank_en;
    logic [3:0] bank_running;
    logic ref_edge;
    logic fs_hi;
    logic [1:0] fs_code;
    logic master_off;
    logic [ADDR_W-1:0] raddr;

    function automatic logic [31:0] cocpc_merge(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_word[8*b +: 8];
            end
        end
        return r;
    endfunction : cocpc_merge

    function automatic logic cocpc_div_hit(input logic [ADDR_W-1:0] a);
        return a >= ADDR_W'(`COCPC_OFF_DIV_FIRST) && a <= ADDR_W'(`COCPC_OFF_DIV_LAST);
    endfunction : cocpc_div_hit

    function automatic logic [3:0] cocpc_div_idx(input logic [ADDR_W-1:0] a);
        return 4'((a - ADDR_W'(`COCPC_OFF_DIV_FIRST)) >> 2);
    endfunction : cocpc_div_idx

    assign pin_in = {ref_clk, pll_locked, device_reset, plan_select_high, plan_select_low,
                     master_out_disable_n, bank3_out_disable_n, bank2_out_disable_n,
                     bank1_out_disable_n, bank0_out_disable_n};
    assign ref_edge = s.sync2[9] & ~s.ref_q;
    assign fs_hi = s.sync2[6];
    assign fs_code = {s.sync2[6], s.sync2[5]};
    assign master_off = s.sync2[4];
    assign raddr = {s_axi_araddr[ADDR_W-1:2], 2'b00};

    // any bank runs only with its own pin low, master low and no plan change
    assign bank_en = ~s.sync2[3:0] & {4{~master_off}} & {4{s.st == cocpc_st_run}};

    always_comb begin
        logic [1:0] fld;
        fld = 2'h0;
        n = s;
        n.sync1 = pin_in;
        n.sync2 = s.sync1;
        n.ref_q = s.sync2[9];

        // reference presence by period window; a stuck input times out
        if (ref_edge) begin
            n.ref_cnt = '0;
            n.ref_present = s.ref_cnt >= 16'(REF_MIN_CYCLES - 1)
                         && s.ref_cnt <= 16'(REF_MAX_CYCLES - 1);
        end else if (s.ref_cnt > 16'(REF_MAX_CYCLES)) begin
            n.ref_present = 1'b0;
        end else begin
            n.ref_cnt = s.ref_cnt + 16'h0001;
        end
        if (s.ctrl[`COCPC_CTRL_BUF]) begin
            n.alarm = ~s.ref_present;
        end else begin
            n.alarm = ~(s.ref_present & s.sync2[8]);
        end

        unique case (s.st)
            cocpc_st_run: begin
                // selects are ignored here; only a reset pulse reloads them
                if (s.ctrl[`COCPC_CTRL_RSTEN] && s.sync2[7]) begin
                    n.st = cocpc_st_hold;
                end
            end
            cocpc_st_hold: begin
                if (!s.sync2[7]) begin
                    n.st = cocpc_st_squelch;
                    n.sq_cnt = 8'h00;
                end
            end
            cocpc_st_squelch: begin
                if (s.sq_cnt < 8'(SQUELCH_CYCLES - 1)) begin
                    n.sq_cnt = s.sq_cnt + 8'h01;
                end else if (bank_running == 4'h0) begin
                    n.st = cocpc_st_load;
                end
            end
            cocpc_st_load: begin
                if (!s.ctrl[`COCPC_CTRL_FSEN]) begin
                    n.plan = 2'h0;
                end else if (!s.ctrl[`COCPC_CTRL_THREE]) begin
                    n.plan = {1'b0, fs_hi};
                end else if (fs_code != 2'h0) begin
                    n.plan = fs_code - 2'h1;
                end
                n.st = cocpc_st_run;
            end
        endcase

        if (s_axi_awvalid && s.awready) begin
            n.aw_have = 1'b1;
            n.awaddr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (n.aw_have && n.w_have && !s.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `COCPC_RESP_OKAY;
            if (n.awaddr == ADDR_W'(`COCPC_OFF_CTRL)) begin
                n.ctrl = 4'(cocpc_merge({28'h0, s.ctrl}, n.wdata, n.wstrb));
            end else if (n.awaddr == ADDR_W'(`COCPC_OFF_IDLE)) begin
                n.idle = 4'(cocpc_merge({28'h0, s.idle}, n.wdata, n.wstrb));
            end else if (n.awaddr == ADDR_W'(`COCPC_OFF_SECFG)) begin
                n.secfg = 8'(cocpc_merge({24'h0, s.secfg}, n.wdata, n.wstrb));
            end else if (n.awaddr == ADDR_W'(`COCPC_OFF_FMT)) begin
                n.fmt = 8'(cocpc_merge({24'h0, s.fmt}, n.wdata, n.wstrb));
            end else if (cocpc_div_hit(n.awaddr)) begin
                n.div[cocpc_div_idx(n.awaddr)] = DIV_W'(cocpc_merge(
                    32'(s.div[cocpc_div_idx(n.awaddr)]), n.wdata, n.wstrb));
            end else if (n.awaddr != ADDR_W'(`COCPC_OFF_STATUS)) begin
                n.bresp = `COCPC_RESP_SLVERR;
            end
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;

        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = `COCPC_RESP_OKAY;
            n.rdata = 32'h0000_0000;
            if (raddr == ADDR_W'(`COCPC_OFF_CTRL)) begin
                n.rdata = {28'h0, s.ctrl};
            end else if (raddr == ADDR_W'(`COCPC_OFF_IDLE)) begin
                n.rdata = {28'h0, s.idle};
            end else if (raddr == ADDR_W'(`COCPC_OFF_SECFG)) begin
                n.rdata = {24'h0, s.secfg};
            end else if (raddr == ADDR_W'(`COCPC_OFF_FMT)) begin
                n.rdata = {24'h0, s.fmt_out};
            end else if (raddr == ADDR_W'(`COCPC_OFF_STATUS)) begin
                n.rdata = {20'h0, bank_running, 2'b00, s.st != cocpc_st_run, s.plan,
                           s.sync2[8], s.ref_present, s.alarm};
            end else if (cocpc_div_hit(raddr)) begin
                n.rdata = 32'(s.div[cocpc_div_idx(raddr)]);
            end else begin
                n.rresp = `COCPC_RESP_SLVERR;
            end
        end
        n.arready = !n.rvalid;

        // current-mode code is replaced while bypassing the PLL
        for (int b = 0; b < 4; b++) begin
            fld = n.fmt[2*b +: 2];
            if (n.ctrl[`COCPC_CTRL_BUF] && fld == `COCPC_FMT_CML) begin
                n.fmt_out[2*b +: 2] = `COCPC_FMT_LVPECL;
            end else begin
                n.fmt_out[2*b +: 2] = fld;
            end
        end

        if (!aresetn) begin
            n = '0;
            n.sync1 = `COCPC_SYNC_RST;
            n.sync2 = `COCPC_SYNC_RST;
            n.alarm = 1'b1;
            // power-on goes through squelch and load, which samples the selects
            n.st = cocpc_st_squelch;
            n.ctrl = `COCPC_CTRL_RST;
            n.idle = `COCPC_IDLE_RST;
            n.secfg = `COCPC_SECFG_RST;
            n.fmt = `COCPC_FMT_RST;
            n.fmt_out = `COCPC_FMT_RST;
            for (int d = 0; d < 12; d++) begin
                n.div[d] = DIV_W'(`COCPC_DIV_RST);
            end
        end
    end

    always_ff @(posedge aclk) begin
        s <= n;
    end

    for (genvar i = 0; i < 4; i++) begin : g_bank
        cocpc_bank_gate #(
            .DIV_W(DIV_W)
        ) u_gate (
            .aclk(aclk),
            .aresetn(aresetn),
            .enable(bank_en[i]),
            .div(s.div[{s.plan, 2'(i)}]),
            .idle_level(s.idle[i]),
            .single_ended(s.secfg[i]),
            .complementary(s.secfg[4+i]),
            .out_a(bank_out_a[i]),
            .out_b(bank_out_b[i]),
            .running(bank_running[i])
        );
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign bank_format = s.fmt_out;
    assign active_plan = s.plan;
    assign ref_missing_alarm = s.alarm;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_master_off: assert property ($rose(master_off)
            |-> ##[1:STOP_MAX] (bank_running == 4'h0 || !master_off))
        else $error("master disable did not stop all banks");
    a_squelch_all: assert property (s.st == cocpc_st_load |-> bank_running == 4'h0)
        else $error("plan loaded while a bank runs");
    a_no_reload: assert property (!s.ctrl[`COCPC_CTRL_RSTEN] && s.st == cocpc_st_run
            |=> s.st == cocpc_st_run)
        else $error("plan change without reset pin");
    a_plan_two: assert property (s.st == cocpc_st_load && s.ctrl[`COCPC_CTRL_FSEN]
            && !s.ctrl[`COCPC_CTRL_THREE] |=> s.plan == {1'b0, $past(fs_hi)})
        else $error("two-plan select decoded wrongly");
    a_plan_three: assert property (s.st == cocpc_st_load && s.ctrl[`COCPC_CTRL_FSEN]
            && s.ctrl[`COCPC_CTRL_THREE] |=> s.plan == (($past(fs_code) == 2'h0)
            ? $past(s.plan) : $past(fs_code) - 2'h1))
        else $error("three-plan select decoded wrongly");
    a_plan_unassigned: assert property (s.st == cocpc_st_load && !s.ctrl[`COCPC_CTRL_FSEN]
            |=> s.plan == 2'h0)
        else $error("plan moved with selects unassigned");
    a_run_stable: assert property (s.st == cocpc_st_run && $past(s.st) == cocpc_st_run
            |-> $stable(s.plan))
        else $error("plan changed during normal operation");
    a_alarm_gen: assert property (!s.ctrl[`COCPC_CTRL_BUF]
            && (!s.ref_present || !s.sync2[8]) |=> s.alarm)
        else $error("alarm low with reference lost or unlocked");
    a_alarm_buf: assert property (s.ctrl[`COCPC_CTRL_BUF] && !s.ref_present |=> s.alarm)
        else $error("buffer mode alarm low without reference");
    a_alarm_clear: assert property (s.ref_present && (s.ctrl[`COCPC_CTRL_BUF] || s.sync2[8])
            && $stable(s.ctrl) |=> !s.alarm)
        else $error("alarm stuck with good reference");
    a_no_cml: assert property (s.ctrl[`COCPC_CTRL_BUF]
            |-> (s.fmt_out & {s.fmt_out[6:0], 1'b0} & 8'haa) == 8'h00)
        else $error("current-mode format in buffer mode");

    c_pin_reload: cover property (s.st == cocpc_st_hold ##[1:100] s.st == cocpc_st_load);
    c_alarm_rise: cover property ($rose(s.alarm));
    c_all_running: cover property (bank_running == 4'hf);
    c_write_done: cover property (s.bvalid && s_axi_bready);

endmodule : cocpc_top

// ---- verif/cocpc_board.sv ----
`timescale 1ns/1ps

module cocpc_board (
    input wire logic aclk,
    input wire logic ref_on,
    input wire logic lock_req,
    output logic ref_clk,
    output logic pll_locked,
    output logic plan_select_low,
    output logic plan_select_high,
    output logic device_reset
);
    int cnt = 0;

    initial {ref_clk, plan_select_high, plan_select_low, device_reset} = 4'h0;
    // no reference means no lock, as a real loop would lose it
    assign pll_locked = lock_req & ref_on;

    // reference stands low while off; period of ten cycles
    always @(posedge aclk) begin
        cnt <= (ref_on && cnt < 4) ? cnt + 1 : 0;
        if (!ref_on)
            ref_clk <= 1'h0;
        else if (cnt == 4)
            ref_clk <= ~ref_clk;
    end

    // selects settle well before the pulse, code 00 only when asked for
    task automatic reload(input logic [1:0] code, input logic pulse);
        @(posedge aclk);
        {plan_select_high, plan_select_low} <= code;
        repeat (4) @(posedge aclk);
        device_reset <= pulse;
        repeat (4) @(posedge aclk);
        device_reset <= 1'h0;
    endtask : reload
endmodule : cocpc_board

// ---- verif/clock_output_plan_control_test.sv ----
`timescale 1ns/1ps
`include "cocpc_cfg.svh"

module clock_output_plan_control_test;
    logic aclk = '0, aresetn = '0, ref_on = '0, lock_req = '0, mdis_n = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, bank_format;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, dis_n = '0, bank_out_a, bank_out_b, idle, m, mv;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, active_plan;
    logic ref_clk, pll_locked, plan_select_low, plan_select_high, device_reset;
    logic ref_missing_alarm;
    logic [1:0] exp_b [$];
    logic [33:0] exp_r [$];
    // {ctrl, select code, pulse, expected plan}
    logic [8:0] tab [9] = '{9'h195, 9'h184, 9'h1cc, 9'h1d5, 9'h1de, 9'h1ca, 9'h1c6,
                            9'h14e, 9'h0dc};
    int mismatches = 0, checked = 0, t0;

    initial forever #10 aclk = ~aclk;

    cocpc_top dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .bank0_out_disable_n(dis_n[0]),
        .bank1_out_disable_n(dis_n[1]), .bank2_out_disable_n(dis_n[2]),
        .bank3_out_disable_n(dis_n[3]), .master_out_disable_n(mdis_n), .plan_select_low,
        .plan_select_high, .device_reset, .pll_locked, .ref_clk, .bank_out_a, .bank_out_b,
        .bank_format, .active_plan, .ref_missing_alarm
    );

    cocpc_board board (
        .aclk, .ref_on, .lock_req, .ref_clk, .pll_locked, .plan_select_low,
        .plan_select_high, .device_reset
    );

    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish;
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // leading edge keeps a release and the next request out of one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = `COCPC_RESP_OKAY);
        @(posedge aclk);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = `COCPC_RESP_OKAY);
        @(posedge aclk);
        exp_r.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask : rd

    // which banks moved, and how often bank 0 changed
    task automatic watch(input int n, output logic [3:0] moved, output int c0);
        logic [3:0] p;
        moved = '0;
        c0 = 0;
        p = bank_out_a;
        repeat (n) begin
            @(posedge aclk);
            moved |= p ^ bank_out_a;
            c0 += int'(p[0] ^ bank_out_a[0]);
            p = bank_out_a;
        end
    endtask : watch

    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0)
            check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
        if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0)
            check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    end

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(59));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        check(34'(ref_missing_alarm), 34'(1'h1));
        rd(`COCPC_OFF_CTRL, 32'(`COCPC_CTRL_RST));
        rd(`COCPC_OFF_IDLE, 32'(`COCPC_IDLE_RST));
        rd(`COCPC_OFF_SECFG, 32'(`COCPC_SECFG_RST));
        rd(`COCPC_OFF_FMT, 32'(`COCPC_FMT_RST));
        rd(`COCPC_OFF_DIV_FIRST, 32'(`COCPC_DIV_RST));
        rd(`COCPC_OFF_DIV_LAST, 32'(`COCPC_DIV_RST));
        rd(8'h20, 32'h0, `COCPC_RESP_SLVERR);
        wr(8'h20, 32'h1, `COCPC_RESP_SLVERR);
        wr(`COCPC_OFF_STATUS, 32'hffffffff);
        repeat (60) @(posedge aclk);
        check(34'(active_plan), 34'(2'h0));
        idle = 4'($urandom());
        m = 4'($urandom());
        wr(`COCPC_OFF_IDLE, 32'(idle));
        mdis_n <= 1'h1;
        repeat (12) @(posedge aclk);
        watch(12, mv, t0);
        check(34'(mv), 34'(4'h0));
        check(34'(bank_out_a), 34'(idle));
        mdis_n <= 1'h0;
        dis_n <= m;
        repeat (12) @(posedge aclk);
        watch(12, mv, t0);
        check(34'(mv), {30'h0, ~m});
        check(34'(bank_out_a & m), 34'(idle & m));
        dis_n <= 4'h0;
        // banks 2 and 3 single-ended, only bank 2 complementary
        wr(`COCPC_OFF_SECFG, 32'h4c);
        repeat (12) @(posedge aclk);
        repeat (4) begin
            @(posedge aclk);
            check(34'(bank_out_a ^ bank_out_b), 34'(4'h7));
        end
        foreach (tab[i]) begin
            wr(`COCPC_OFF_CTRL, 32'(tab[i][8:5]));
            fork
                board.reload(tab[i][4:3], tab[i][2]);
                if (i == 0) begin
                    repeat (16) @(posedge aclk);
                    watch(4, mv, t0);
                    check(34'(mv), 34'(4'h0));
                    check(34'(bank_out_a), 34'(idle));
                end
            join
            repeat (60) @(posedge aclk);
            check(34'(active_plan), 34'(tab[i][1:0]));
        end
        wr(`COCPC_OFF_CTRL, 32'hd);
        wr(`COCPC_OFF_FMT, 32'hff);
        rd(`COCPC_OFF_FMT, 32'haa);
        check(34'(bank_format), 34'(8'haa));
        ref_on <= 1'h1;
        repeat (60) @(posedge aclk);
        check(34'(ref_missing_alarm), 34'(1'h0));
        ref_on <= 1'h0;
        repeat (130) @(posedge aclk);
        check(34'(ref_missing_alarm), 34'(1'h1));
        wr(`COCPC_OFF_CTRL, 32'hc);
        rd(`COCPC_OFF_FMT, 32'hff);
        check(34'(bank_format), 34'(8'hff));
        ref_on <= 1'h1;
        lock_req <= 1'h1;
        repeat (60) @(posedge aclk);
        check(34'(ref_missing_alarm), 34'(1'h0));
        lock_req <= 1'h0;
        repeat (5) @(posedge aclk);
        check(34'(ref_missing_alarm), 34'(1'h1));
        // half period of two cycles gives twenty changes in forty
        watch(40, mv, t0);
        check(34'(t0), 34'(20));
        tally_and_finish();
    end
endmodule : clock_output_plan_control_test
